//--- include/irm_pkg.sv
package irm_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNTER_CONTROL = 8'h04;
  localparam logic [7:0] OFS_DATA_COUNTER_VALUE = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_PULSE_LENGTH = 8'h0c;
  localparam logic [7:0] OFS_DATA_CYCLE_LENGTH = 8'h10;
  localparam logic [7:0] OFS_STATUS_AND_FLAGS = 8'h14;
  localparam logic [7:0] OFS_INTERRUPT_ENABLES = 8'h18;
  localparam logic [7:0] OFS_CARRIER_WAVEFORM = 8'h1c;
  localparam logic [7:0] OFS_CARRIER_MOD_CONTROL = 8'h20;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CLK_DEBUG_RUN = 8;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_SRC_LSB = 0;
  localparam int CTL_COUNTER_RESET = 9;
  localparam int CTL_COUNTER_RUN = 8;
  localparam int CTL_OUTPUT_INVERT = 4;
  localparam int CTL_BUFFER_ENABLE = 3;
  localparam int CTL_COUNTER_MODE = 2;
  localparam int CTL_SOFTWARE_RESET = 1;
  localparam int CTL_MODULE_ENABLE = 0;
  localparam int STS_COUNTER_RUNNING = 10;
  localparam int STS_CYCLE_BUSY = 9;
  localparam int STS_ACTIVE_BUSY = 8;
  localparam int STS_CYCLE_FLAG = 1;
  localparam int STS_ACTIVE_FLAG = 0;
  localparam int CARR_DUTY_LSB = 8;
  localparam int CARR_PERIOD_LSB = 0;
  localparam int CCTL_MOD_ENABLE = 0;

  // ==========================================================================
  // Reset values and clock codes
  // ==========================================================================
  localparam logic [15:0] RST_LENGTH = 16'h0000;
  localparam logic [7:0] RST_CARRIER = 8'h00;
  localparam logic [3:0] RST_DIVIDER = 4'h0;
  localparam logic [3:0] DIV_LOW_XTAL_NONE = 4'hf;
  localparam logic [3:0] DIV_LOW_XTAL_MAX = 4'h8;

  typedef enum logic [1:0] {
    IRM_SRC_INTERNAL = 2'h0,
    IRM_SRC_LOW_XTAL = 2'h1,
    IRM_SRC_HIGH_OSC = 2'h2,
    IRM_SRC_EXTERNAL = 2'h3
  } irm_src_type;

  typedef struct packed {
    logic output_invert;
    logic buffer_enable;
    logic counter_mode;
    logic module_enable;
  } irm_ctl_type;

endpackage

//--- hw/irm_clk_div.sv
`timescale 1ns/1ps
module irm_clk_div (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] src_pins,
  input wire irm_pkg::irm_src_type clock_source_select,
  input wire logic [3:0] clock_divider,
  input wire logic gate_on,
  output logic tick
);

  // ==========================================================================
  // Source synchronisers
  // ==========================================================================
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [14:0] cnt_ff;
  logic [14:0] mask;
  logic src_edge;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
          sync3_ff[g] <= 1'b0;
        end else begin
          sync1_ff[g] <= src_pins[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Division ratio
  // ==========================================================================
  function automatic logic [14:0] div_mask(input irm_pkg::irm_src_type src,
                                           input logic [3:0] div);
    logic [15:0] full;
    full = (16'h0001 << div) - 16'h0001;
    case (src)
      irm_pkg::IRM_SRC_EXTERNAL: div_mask = 15'h0000;
      irm_pkg::IRM_SRC_LOW_XTAL: begin
        if (div == irm_pkg::DIV_LOW_XTAL_NONE) begin
          div_mask = 15'h0000;
        end else if (div > irm_pkg::DIV_LOW_XTAL_MAX) begin
          div_mask = 15'h00ff;
        end else begin
          div_mask = full[14:0];
        end
      end
      default: div_mask = full[14:0];
    endcase
  endfunction

  assign mask = div_mask(clock_source_select, clock_divider);
  assign src_edge = sync2_ff[clock_source_select] & ~sync3_ff[clock_source_select];

  // A stopped gate also parks the divider so the first tick after enable is a full period.
  always_ff @(posedge sys_clk) begin
    if (srst || !gate_on) begin
      cnt_ff <= 15'h0000;
    end else if (src_edge) begin
      cnt_ff <= cnt_ff + 15'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tick <= 1'b0;
    end else begin
      tick <= gate_on && src_edge && ((cnt_ff & mask) == mask);
    end
  end

endmodule

//--- hw/irm_top.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
//
// Behaviour
// - Debug-run keeps operating clock during debug halt
// - Two-bit select picks one of four sources
// - Divider is power of two per source
// - Counter reset clears both counters, self-clears
// - Run bit starts, stops; one-shot end clears
// - Invert bit flips output polarity
// - Buffer enable selects buffered or direct compare
// - Counter mode selects one-shot or repeat
// - Software reset clears counters, flags, run, counter reset; busy status kept
// - Module enable gates the operating clock
// - Data counter value is readable
// - Data active from zero through active length
// - Length writes accepted only while enabled
// - Data cycle wraps after cycle length
// - Running status shows counter activity
// - Busy flags block writes until transferred
// - Match flags sticky, write one clears
// - Two enables gate the two interrupts
// - Carrier high through duty, wraps at period
// - Output is carrier AND data before inversion
// - Buffered lengths load at cycle match
// - Interrupt only for enabled set flag
// - Modulation enable selects carrier or bare data
module irm_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [3:0] clk_src_pins,
  input wire logic debug_halt,
  output logic remote_output,
  output logic irq
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic debug_run_ff;
  logic [3:0] clock_divider_ff;
  irm_pkg::irm_src_type clock_source_select_ff;
  irm_pkg::irm_ctl_type ctl_ff;
  logic counter_reset_ff;
  logic counter_run_ff;
  logic software_reset_ff;
  logic [15:0] active_length_ff;
  logic [15:0] cycle_length_ff;
  logic [15:0] active_buf_ff;
  logic [15:0] cycle_buf_ff;
  logic active_busy_ff;
  logic cycle_busy_ff;
  logic active_flag_ff;
  logic cycle_flag_ff;
  logic active_ie_ff;
  logic cycle_ie_ff;
  logic [7:0] carrier_duty_ff;
  logic [7:0] carrier_period_ff;
  logic carrier_mod_enable_ff;
  logic [15:0] data_counter_ff;
  logic [7:0] carrier_counter_ff;
  logic remote_output_ff;
  logic irq_ff;
  logic [15:0] reg_rdata_ff;

  logic tick;
  logic gate_on;
  logic wr_clk;
  logic wr_ctl;
  logic wr_ap;
  logic wr_db;
  logic wr_intf;
  logic ap_accept;
  logic db_accept;
  logic step;
  logic [15:0] cmp_active;
  logic [15:0] cmp_cycle;
  logic ap_match;
  logic db_match;
  logic carrier_level;
  logic data_level;
  logic nxt_remote_output;

  assign wr_clk = reg_wr && (reg_addr == irm_pkg::OFS_CLOCK_CONTROL);
  assign wr_ctl = reg_wr && (reg_addr == irm_pkg::OFS_COUNTER_CONTROL);
  assign wr_ap = reg_wr && (reg_addr == irm_pkg::OFS_ACTIVE_PULSE_LENGTH);
  assign wr_db = reg_wr && (reg_addr == irm_pkg::OFS_DATA_CYCLE_LENGTH);
  assign wr_intf = reg_wr && (reg_addr == irm_pkg::OFS_STATUS_AND_FLAGS);

  // ==========================================================================
  // Operating clock
  // ==========================================================================
  assign gate_on = ctl_ff.module_enable && (debug_run_ff || !debug_halt);

  irm_clk_div u_clk_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .src_pins(clk_src_pins),
    .clock_source_select(clock_source_select_ff),
    .clock_divider(clock_divider_ff),
    .gate_on(gate_on),
    .tick(tick)
  );

  // Clock settings are frozen while enabled so the divider never sees a glitching ratio.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      debug_run_ff <= 1'b0;
      clock_divider_ff <= irm_pkg::RST_DIVIDER;
      clock_source_select_ff <= irm_pkg::IRM_SRC_INTERNAL;
    end else if (wr_clk && !ctl_ff.module_enable) begin
      debug_run_ff <= reg_wdata[irm_pkg::CLK_DEBUG_RUN];
      clock_divider_ff <= reg_wdata[irm_pkg::CLK_DIV_LSB +: 4];
      clock_source_select_ff <= irm_pkg::irm_src_type'(reg_wdata[irm_pkg::CLK_SRC_LSB +: 2]);
    end
  end

  // ==========================================================================
  // Control bits
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctl_ff <= '0;
    end else if (wr_ctl) begin
      ctl_ff.output_invert <= reg_wdata[irm_pkg::CTL_OUTPUT_INVERT];
      ctl_ff.buffer_enable <= reg_wdata[irm_pkg::CTL_BUFFER_ENABLE];
      ctl_ff.counter_mode <= reg_wdata[irm_pkg::CTL_COUNTER_MODE];
      ctl_ff.module_enable <= reg_wdata[irm_pkg::CTL_MODULE_ENABLE];
    end
  end

  // The software reset acts one cycle after its write and then drops by itself.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      software_reset_ff <= 1'b0;
    end else begin
      software_reset_ff <= wr_ctl && reg_wdata[irm_pkg::CTL_SOFTWARE_RESET];
    end
  end

  // A counter reset waits for the next operating clock tick, like the counters it clears.
  always_ff @(posedge sys_clk) begin
    if (srst || software_reset_ff) begin
      counter_reset_ff <= 1'b0;
    end else if (wr_ctl && reg_wdata[irm_pkg::CTL_COUNTER_RESET] && ctl_ff.module_enable) begin
      counter_reset_ff <= 1'b1;
    end else if (tick) begin
      counter_reset_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || software_reset_ff) begin
      counter_run_ff <= 1'b0;
    end else if (wr_ctl) begin
      counter_run_ff <= reg_wdata[irm_pkg::CTL_COUNTER_RUN] && ctl_ff.module_enable;
    end else if (db_match && ctl_ff.counter_mode) begin
      counter_run_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Length registers and compare buffers
  // ==========================================================================
  assign ap_accept = wr_ap && ctl_ff.module_enable && !active_busy_ff;
  assign db_accept = wr_db && ctl_ff.module_enable && !cycle_busy_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_length_ff <= irm_pkg::RST_LENGTH;
    end else if (ap_accept) begin
      active_length_ff <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cycle_length_ff <= irm_pkg::RST_LENGTH;
    end else if (db_accept) begin
      cycle_length_ff <= reg_wdata;
    end
  end

  // With buffering off the buffers track the registers, so enabling later starts coherent.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_buf_ff <= irm_pkg::RST_LENGTH;
      cycle_buf_ff <= irm_pkg::RST_LENGTH;
    end else if (!ctl_ff.buffer_enable || db_match) begin
      active_buf_ff <= active_length_ff;
      cycle_buf_ff <= cycle_length_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_busy_ff <= 1'b0;
      cycle_busy_ff <= 1'b0;
    end else begin
      if (ap_accept && ctl_ff.buffer_enable) begin
        active_busy_ff <= 1'b1;
      end else if (db_match || !ctl_ff.buffer_enable) begin
        active_busy_ff <= 1'b0;
      end
      if (db_accept && ctl_ff.buffer_enable) begin
        cycle_busy_ff <= 1'b1;
      end else if (db_match || !ctl_ff.buffer_enable) begin
        cycle_busy_ff <= 1'b0;
      end
    end
  end

  assign cmp_active = ctl_ff.buffer_enable ? active_buf_ff : active_length_ff;
  assign cmp_cycle = ctl_ff.buffer_enable ? cycle_buf_ff : cycle_length_ff;

  // ==========================================================================
  // Counters
  // ==========================================================================
  assign step = tick && counter_run_ff && !counter_reset_ff && !software_reset_ff;
  assign ap_match = step && (data_counter_ff == cmp_active);
  assign db_match = step && (data_counter_ff == cmp_cycle);

  always_ff @(posedge sys_clk) begin
    if (srst || software_reset_ff) begin
      data_counter_ff <= 16'h0000;
    end else if (tick && counter_reset_ff) begin
      data_counter_ff <= 16'h0000;
    end else if (db_match) begin
      data_counter_ff <= 16'h0000;
    end else if (step) begin
      data_counter_ff <= data_counter_ff + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || software_reset_ff) begin
      carrier_counter_ff <= 8'h00;
    end else if (tick && counter_reset_ff) begin
      carrier_counter_ff <= 8'h00;
    end else if (step && carrier_counter_ff == carrier_period_ff) begin
      carrier_counter_ff <= 8'h00;
    end else if (step) begin
      carrier_counter_ff <= carrier_counter_ff + 8'h01;
    end
  end

  // ==========================================================================
  // Flags and interrupt
  // ==========================================================================
  // A match in the same cycle as a write-one clear keeps the flag set.
  always_ff @(posedge sys_clk) begin
    if (srst || software_reset_ff) begin
      active_flag_ff <= 1'b0;
      cycle_flag_ff <= 1'b0;
    end else begin
      if (ap_match) begin
        active_flag_ff <= 1'b1;
      end else if (wr_intf && reg_wdata[irm_pkg::STS_ACTIVE_FLAG]) begin
        active_flag_ff <= 1'b0;
      end
      if (db_match) begin
        cycle_flag_ff <= 1'b1;
      end else if (wr_intf && reg_wdata[irm_pkg::STS_CYCLE_FLAG]) begin
        cycle_flag_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_ie_ff <= 1'b0;
      cycle_ie_ff <= 1'b0;
    end else if (reg_wr && reg_addr == irm_pkg::OFS_INTERRUPT_ENABLES) begin
      active_ie_ff <= reg_wdata[irm_pkg::STS_ACTIVE_FLAG];
      cycle_ie_ff <= reg_wdata[irm_pkg::STS_CYCLE_FLAG];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (active_flag_ff && active_ie_ff) || (cycle_flag_ff && cycle_ie_ff);
    end
  end

  // ==========================================================================
  // Carrier settings and output
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      carrier_duty_ff <= irm_pkg::RST_CARRIER;
      carrier_period_ff <= irm_pkg::RST_CARRIER;
    end else if (reg_wr && reg_addr == irm_pkg::OFS_CARRIER_WAVEFORM) begin
      carrier_duty_ff <= reg_wdata[irm_pkg::CARR_DUTY_LSB +: 8];
      carrier_period_ff <= reg_wdata[irm_pkg::CARR_PERIOD_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      carrier_mod_enable_ff <= 1'b0;
    end else if (reg_wr && reg_addr == irm_pkg::OFS_CARRIER_MOD_CONTROL) begin
      carrier_mod_enable_ff <= reg_wdata[irm_pkg::CCTL_MOD_ENABLE];
    end
  end

  assign carrier_level = (carrier_counter_ff <= carrier_duty_ff);
  assign data_level = (data_counter_ff <= cmp_active);

  // An idle block holds the inactive level, so the LED is dark between transmissions.
  always_comb begin
    nxt_remote_output = 1'b0;
    if (counter_run_ff && ctl_ff.module_enable) begin
      if (carrier_mod_enable_ff) begin
        nxt_remote_output = carrier_level && data_level;
      end else begin
        nxt_remote_output = data_level;
      end
    end
    nxt_remote_output = nxt_remote_output ^ ctl_ff.output_invert;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      remote_output_ff <= 1'b0;
    end else begin
      remote_output_ff <= nxt_remote_output;
    end
  end

  // ==========================================================================
  // Read port
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata_ff <= 16'h0000;
    end else if (reg_addr == irm_pkg::OFS_CLOCK_CONTROL) begin
      reg_rdata_ff <= {7'h00, debug_run_ff, clock_divider_ff, 2'h0, clock_source_select_ff};
    end else if (reg_addr == irm_pkg::OFS_COUNTER_CONTROL) begin
      reg_rdata_ff <= {6'h00, counter_reset_ff, counter_run_ff, 3'h0, ctl_ff.output_invert,
                       ctl_ff.buffer_enable, ctl_ff.counter_mode, software_reset_ff,
                       ctl_ff.module_enable};
    end else if (reg_addr == irm_pkg::OFS_DATA_COUNTER_VALUE) begin
      reg_rdata_ff <= data_counter_ff;
    end else if (reg_addr == irm_pkg::OFS_ACTIVE_PULSE_LENGTH) begin
      reg_rdata_ff <= active_length_ff;
    end else if (reg_addr == irm_pkg::OFS_DATA_CYCLE_LENGTH) begin
      reg_rdata_ff <= cycle_length_ff;
    end else if (reg_addr == irm_pkg::OFS_STATUS_AND_FLAGS) begin
      reg_rdata_ff <= {5'h00, counter_run_ff, cycle_busy_ff, active_busy_ff, 6'h00,
                       cycle_flag_ff, active_flag_ff};
    end else if (reg_addr == irm_pkg::OFS_INTERRUPT_ENABLES) begin
      reg_rdata_ff <= {14'h0000, cycle_ie_ff, active_ie_ff};
    end else if (reg_addr == irm_pkg::OFS_CARRIER_WAVEFORM) begin
      reg_rdata_ff <= {carrier_duty_ff, carrier_period_ff};
    end else if (reg_addr == irm_pkg::OFS_CARRIER_MOD_CONTROL) begin
      reg_rdata_ff <= {15'h0000, carrier_mod_enable_ff};
    end else begin
      reg_rdata_ff <= 16'h0000;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign remote_output = remote_output_ff;
  assign irq = irq_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_gate_stops_tick;
    @(posedge sys_clk) disable iff (srst)
    !ctl_ff.module_enable |=> !tick;
  endproperty
  a_gate_stops_tick: assert property (p_gate_stops_tick) else $error("tick while disabled");

  property p_debug_halt;
    @(posedge sys_clk) disable iff (srst)
    (debug_halt && !debug_run_ff) [*2] |-> !tick;
  endproperty
  a_debug_halt: assert property (p_debug_halt) else $error("tick during debug halt");

  property p_cycle_wrap;
    @(posedge sys_clk) disable iff (srst)
    db_match |=> (data_counter_ff == 16'h0000) && cycle_flag_ff;
  endproperty
  a_cycle_wrap: assert property (p_cycle_wrap) else $error("data counter did not wrap");

  property p_one_shot_stop;
    @(posedge sys_clk) disable iff (srst)
    (db_match && ctl_ff.counter_mode && !wr_ctl) |=> !counter_run_ff;
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");

  property p_carrier_wrap;
    @(posedge sys_clk) disable iff (srst)
    (step && carrier_counter_ff == carrier_period_ff) |=> (carrier_counter_ff == 8'h00);
  endproperty
  a_carrier_wrap: assert property (p_carrier_wrap) else $error("carrier did not wrap");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (srst)
    software_reset_ff |=> (data_counter_ff == 16'h0000) && !counter_run_ff
      && !active_flag_ff && !cycle_flag_ff && !counter_reset_ff;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset incomplete");

  property p_busy_blocks;
    @(posedge sys_clk) disable iff (srst)
    (wr_ap && active_busy_ff) |=> $stable(active_length_ff);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("write taken while busy");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (srst)
    ((cycle_flag_ff && cycle_ie_ff) || (active_flag_ff && active_ie_ff)) |=> irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("enabled flag raised no irq");

  property p_active_level;
    @(posedge sys_clk) disable iff (srst)
    (counter_run_ff && ctl_ff.module_enable && !carrier_mod_enable_ff && data_level)
      |=> (remote_output != $past(ctl_ff.output_invert));
  endproperty
  a_active_level: assert property (p_active_level) else $error("data not active");

  property p_counter_reset;
    @(posedge sys_clk) disable iff (srst)
    (tick && counter_reset_ff) |=> (data_counter_ff == 16'h0000)
      && (carrier_counter_ff == 8'h00) && !counter_reset_ff;
  endproperty
  a_counter_reset: assert property (p_counter_reset) else $error("counter reset failed");

endmodule

//--- testbench/irm_src_model.sv
`timescale 1ns/1ps
// Free-running source clocks; the internal one rises every 4 cycles to keep runs short.
module irm_src_model (
  input wire logic sys_clk,
  output logic [3:0] clk_src_pins
);
  logic [3:0] cnt_ff = 4'h0;
  always @(posedge sys_clk) begin
    cnt_ff <= cnt_ff + 4'h1;
  end
  assign clk_src_pins = {cnt_ff[3:1], cnt_ff[1]};
endmodule

//--- testbench/test_ir_remote_carrier_modulator.sv
`timescale 1ns/1ps
module test_ir_remote_carrier_modulator;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic debug_halt = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] clk_src_pins;
  logic remote_output;
  logic irq;
  logic [15:0] mdl [9];
  logic [1:0] bz = 2'h0;
  logic [15:0] v1;
  logic [15:0] v2;
  int num_errors = 0;
  int num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  irm_src_model src (.sys_clk(sys_clk), .clk_src_pins(clk_src_pins));
  irm_top dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_src_pins(clk_src_pins),
    .debug_halt(debug_halt), .remote_output(remote_output), .irq(irq));
  // ==========================================================================
  // Bus tasks and model.
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  // Enable is judged on its value before the write, as the hardware does.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic en;
    en = mdl[1][0];
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // An idle cycle keeps back-to-back writes from driving the strobe twice in one step.
    @(posedge sys_clk);
    case (a)
      8'h00: if (!en) mdl[0] = d & 16'h01f3;
      8'h04: begin
        mdl[1] = d & (en ? 16'h011d : 16'h001d);
        if (!d[3]) bz = 2'h0;
      end
      8'h0c, 8'h10: if (en && !bz[a[4]]) begin
        mdl[a[7:2]] = d;
        bz[a[4]] = mdl[1][3];
      end
      8'h18: mdl[6] = d & 16'h0003;
      8'h1c: mdl[7] = d;
      8'h20: mdl[8] = d & 16'h0001;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic chk_all();
    for (int i = 0; i < 10; i++) begin
      rd(8'(i * 4), v1);
      chk(v1, i < 9 ? mdl[i] : 16'h0000);
    end
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic val);
    for (int n = 0; n < 200; n++) begin
      rd(a, v1);
      if (v1[b] === val) return;
    end
    num_errors++;
    wrap_up();
  endtask
  initial begin
    for (int i = 0; i < 9; i++) begin
      mdl[i] = 16'h0000;
    end
    void'($urandom(32'heb89_c081));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk_all();
    wr(8'h0c, 16'($urandom()));
    for (int s = 3; s >= 0; s--) begin
      wr(8'h00, 16'(s) | (16'($urandom_range(15)) << 4));
      rd(8'h00, v1);
      chk(v1, mdl[0]);
    end
    // A short fixed ratio keeps every later wait inside its bound.
    wr(8'h00, 16'h0010);
    wr(8'h1c, 16'($urandom()));
    wr(8'h18, 16'($urandom()));
    chk_all();
    wr(8'h04, 16'h0001);
    wr(8'h00, 16'h0033);
    wr(8'h0c, 16'h0002);
    wr(8'h10, 16'h0005);
    wr(8'h18, 16'h0000);
    wr(8'h20, 16'h0000);
    chk_all();
    wr(8'h04, 16'h0101);
    // Any window of one data period holds the same count of active cycles, whatever its phase.
    repeat (60) @(posedge sys_clk);
    v2 = 16'h0000;
    for (int n = 0; n < 48; n++) begin
      @(negedge sys_clk);
      v2 = v2 + 16'(remote_output);
    end
    chk(v2, 16'h0018);
    @(posedge sys_clk);
    wait_bit(8'h14, 10, 1'b1);
    wait_bit(8'h14, 1, 1'b1);
    wr(8'h18, 16'h0002);
    repeat (3) @(negedge sys_clk);
    chk(16'(irq), 16'h0001);
    @(posedge sys_clk);
    debug_halt <= 1'b1;
    // A tick already in flight when the halt rises may still step the counter.
    repeat (2) @(posedge sys_clk);
    rd(8'h08, v2);
    repeat (40) @(posedge sys_clk);
    rd(8'h08, v1);
    chk(v1, v2);
    debug_halt <= 1'b0;
    wr(8'h04, 16'h0001);
    wr(8'h14, 16'h0003);
    rd(8'h14, v1);
    chk(v1, 16'h0000);
    wr(8'h04, 16'h0011);
    repeat (3) @(negedge sys_clk);
    chk(16'(remote_output), 16'h0001);
    @(posedge sys_clk);
    wr(8'h04, 16'h0009);
    wr(8'h10, 16'h0009);
    wr(8'h10, 16'h0003);
    rd(8'h14, v1);
    chk(v1, 16'h0200);
    wr(8'h04, 16'h0005);
    wr(8'h04, 16'h0105);
    wait_bit(8'h04, 8, 1'b0);
    rd(8'h08, v1);
    chk(v1, 16'h0000);
    wr(8'h04, 16'h0101);
    repeat (40) @(posedge sys_clk);
    wr(8'h04, 16'h0201);
    wait_bit(8'h04, 9, 1'b0);
    rd(8'h08, v1);
    chk(v1, 16'h0000);
    wr(8'h04, 16'h0101);
    repeat (40) @(posedge sys_clk);
    wr(8'h04, 16'h0100);
    wr(8'h04, 16'h0007);
    repeat (2) @(posedge sys_clk);
    chk_all();
    wrap_up();
  end
endmodule
